// ===== rtl/gpint_pkg.sv
// Package: register map, field layouts and types for the GPIO and pin interrupt block
package gpint_pkg;
	localparam int NPIN = 48;
	localparam int P0W = 32;
	localparam int P1W = 16;
	localparam int NSEL = 8;
	localparam int SELW = 6;
	localparam int AW = 8;
	// GPIO, port p at +4*p
	localparam logic [AW-1:0] DIR_OFS = 8'h00;
	localparam logic [AW-1:0] MASK_OFS = 8'h08;
	localparam logic [AW-1:0] PIN_OFS = 8'h10;
	localparam logic [AW-1:0] MPIN_OFS = 8'h18;
	localparam logic [AW-1:0] SET_OFS = 8'h20;
	localparam logic [AW-1:0] CLR_OFS = 8'h28;
	localparam logic [AW-1:0] NOT_OFS = 8'h30;
	localparam logic [AW-1:0] OUT_OFS = 8'h38;
	// Pin interrupt and pattern engine
	localparam logic [AW-1:0] SEL_LO_OFS = 8'h40;
	localparam logic [AW-1:0] SEL_HI_OFS = 8'h44;
	localparam logic [AW-1:0] MODE_OFS = 8'h48;
	localparam logic [AW-1:0] RISE_OFS = 8'h4c;
	localparam logic [AW-1:0] FALL_OFS = 8'h50;
	localparam logic [AW-1:0] REQ_OFS = 8'h54;
	localparam logic [AW-1:0] PLVL_OFS = 8'h58;
	localparam logic [AW-1:0] PEDG_OFS = 8'h5c;
	localparam logic [AW-1:0] PEN_OFS = 8'h60;
	localparam logic [AW-1:0] PHIT_OFS = 8'h64;
	localparam logic [AW-1:0] GRP_OFS = 8'h68;
	localparam logic [AW-1:0] GPOL_OFS = 8'h6c;
	localparam logic [AW-1:0] GCTL_OFS = 8'h70;
	// Group control fields
	localparam int GCTL_AND = 0;
	localparam int PEV_EN = 1;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;
	localparam logic [31:0] ZERO32 = 32'h00000000;
	typedef struct packed {
		logic [NPIN-1:0] dir;
		logic [NPIN-1:0] mask;
		logic [NPIN-1:0] outv;
	} gpint_port_type;
	typedef struct packed {
		logic [NSEL-1:0] mode;
		logic [NSEL-1:0] rise;
		logic [NSEL-1:0] fall;
		logic [NSEL-1:0] plvl;
		logic [NSEL-1:0] pedg;
		logic [NSEL-1:0] pen;
		logic [NPIN-1:0] grp;
		logic [NPIN-1:0] gpol;
		logic [1:0] gctl;
		logic [NSEL*SELW-1:0] sel;
	} gpint_cfg_type;
endpackage : gpint_pkg

// ===== rtl/gpint_top.sv
// GPIO ports with pin interrupts, pattern matcher and group interrupt, AXI4-Lite slave
//
// Overview of operation
// - Two ports, 32 and 16 bits, give 48 general-purpose pins.
// - Every pin has its own direction bit, writable at any time.
// - Reset clears all direction bits, so every pin starts as input.
// - Set and clear registers drive ones high or low; zeros leave bits alone.
// - Toggle register inverts every bit written as one within one port.
// - Pin reads return the pin level whatever function owns the pin.
// - Mask registers limit masked reads and writes to selected bits.
// - All registers except PIN accept byte, half-word and word writes per strobe.
// - The whole output value of a port is written in one access.
// - Eight selectors pick interrupt source pins from any of the 48 pins.
// - Each selected pin drives its own interrupt line.
// - Edge mode requests on rising, falling or both edges.
// - Level mode requests while the pin sits at the active level.
// - Detection runs on the system clock; wake gating lies outside.
// - Pattern terms combine levels and transitions of the eight pins.
// - One product term ANDs all enabled slices; a match sets termIrq of every enabled slice.
// - A match can pulse the core event, also offered for a pin.
// - Pattern wake is flagged as not usable in deep sleep.
// - Pin selection ignores the pin's peripheral function.
// - Every register access completes with minimal fixed latency.
// - Group interrupt fires when selected pins meet an AND or OR condition.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module gpint_top
	import gpint_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// AXI4-Lite slave
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins
	input wire logic [NPIN-1:0] pinIn,
	output logic [NPIN-1:0] pinOut,
	output logic [NPIN-1:0] pinOe,
	// Interrupts and events
	output logic [NSEL-1:0] pinIrq,
	output logic [NSEL-1:0] termIrq,
	output logic groupIrq,
	output logic corePulse,
	output logic corePulsePin,
	output logic patWakeDeepOk
);
	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	logic [NPIN-1:0] syncA_ff, syncB_ff;
	logic [NSEL-1:0] selLvl, selPrev_ff;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			syncA_ff <= '0;
			syncB_ff <= '0;
		end
		else
		begin
			syncA_ff <= pinIn;
			syncB_ff <= syncA_ff;
		end
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	gpint_port_type prt_ff, nxt_prt;
	gpint_cfg_type cfg_ff, nxt_cfg;
	logic [NSEL-1:0] req_ff, nxt_req;
	logic [NSEL-1:0] hit_ff, nxt_hit;
	logic [NSEL-1:0] riseEv, fallEv, edgeReq, term;
	logic anyMatch, prevMatch_ff, groupHit;
	logic wrDo, rdDo;
	logic [AW-1:0] awAddr_ff, arAddr_ff;
	logic awHave_ff, wHave_ff, bValid_ff, rValid_ff;
	logic [31:0] wData_ff, rData_ff, nxt_rdata;
	logic [3:0] wStrb_ff;
	logic rErr_ff, bErr_ff, nxt_rerr, wrHit;

	// Selector mux, any pin regardless of function
	genvar g;
	generate
		for (g = 0; g < NSEL; g++)
		begin : g_sel
			logic [SELW-1:0] idx;
			assign idx = cfg_ff.sel[g*SELW +: SELW];
			assign selLvl[g] = (idx < SELW'(NPIN)) ? syncB_ff[idx] : 1'b0;
			assign riseEv[g] = selLvl[g] & ~selPrev_ff[g];
			assign fallEv[g] = ~selLvl[g] & selPrev_ff[g];
			assign edgeReq[g] = (cfg_ff.rise[g] & riseEv[g]) | (cfg_ff.fall[g] & fallEv[g]);
			// Level mode: rise bit enables, fall bit picks low-active
			assign pinIrq[g] = cfg_ff.mode[g] ? (cfg_ff.rise[g] & (selLvl[g] ^ cfg_ff.fall[g])) : req_ff[g];
			// Term: pedg picks transition vs level, plvl picks polarity
			assign term[g] = ~cfg_ff.pen[g] | (cfg_ff.pedg[g] ? (cfg_ff.plvl[g] ? riseEv[g] : fallEv[g])
				: (selLvl[g] == cfg_ff.plvl[g]));
		end
	endgenerate

	assign anyMatch = (&term) & (|cfg_ff.pen);
	assign termIrq = hit_ff;
	assign groupHit = cfg_ff.gctl[GCTL_AND]
		? (((syncB_ff ^ ~cfg_ff.gpol) & cfg_ff.grp) == cfg_ff.grp) & (|cfg_ff.grp)
		: |((syncB_ff ^ ~cfg_ff.gpol) & cfg_ff.grp);
	assign patWakeDeepOk = 1'b0;
	assign pinOut = prt_ff.outv;
	assign pinOe = prt_ff.dir;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	assign s_axi_awready = ~awHave_ff;
	assign s_axi_wready = ~wHave_ff;
	assign s_axi_arready = ~rValid_ff;
	assign s_axi_bvalid = bValid_ff;
	assign s_axi_rvalid = rValid_ff;
	assign s_axi_rdata = rData_ff;
	assign s_axi_bresp = bErr_ff ? RESP_ERR : RESP_OK;
	assign s_axi_rresp = rErr_ff ? RESP_ERR : RESP_OK;
	assign wrDo = awHave_ff & wHave_ff & ~bValid_ff;
	assign rdDo = s_axi_arvalid & ~rValid_ff;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			awHave_ff <= 1'b0;
			wHave_ff <= 1'b0;
			bValid_ff <= 1'b0;
			rValid_ff <= 1'b0;
			bErr_ff <= 1'b0;
			rErr_ff <= 1'b0;
			awAddr_ff <= '0;
			wData_ff <= '0;
			wStrb_ff <= '0;
			rData_ff <= '0;
		end
		else
		begin
			if (s_axi_awvalid & ~awHave_ff)
			begin
				awHave_ff <= 1'b1;
				awAddr_ff <= s_axi_awaddr;
			end
			else if (wrDo)
				awHave_ff <= 1'b0;
			if (s_axi_wvalid & ~wHave_ff)
			begin
				wHave_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			else if (wrDo)
				wHave_ff <= 1'b0;
			if (wrDo)
			begin
				bValid_ff <= 1'b1;
				bErr_ff <= ~wrHit;
			end
			else if (s_axi_bready)
				bValid_ff <= 1'b0;
			if (rdDo)
			begin
				rValid_ff <= 1'b1;
				rData_ff <= nxt_rdata;
				rErr_ff <= nxt_rerr;
			end
			else if (s_axi_rready)
				rValid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [NPIN-1:0] pinv;
		logic hiPort;
		pinv = syncB_ff;
		hiPort = s_axi_araddr[2];
		nxt_rerr = 1'b0;
		nxt_rdata = ZERO32;
		unique case ({s_axi_araddr[AW-1:3], 3'b000})
			DIR_OFS: nxt_rdata = hiPort ? 32'(prt_ff.dir[NPIN-1:P0W]) : prt_ff.dir[P0W-1:0];
			MASK_OFS: nxt_rdata = hiPort ? 32'(prt_ff.mask[NPIN-1:P0W]) : prt_ff.mask[P0W-1:0];
			PIN_OFS: nxt_rdata = hiPort ? 32'(pinv[NPIN-1:P0W]) : pinv[P0W-1:0];
			MPIN_OFS: nxt_rdata = hiPort ? 32'(pinv[NPIN-1:P0W] & ~prt_ff.mask[NPIN-1:P0W])
				: (pinv[P0W-1:0] & ~prt_ff.mask[P0W-1:0]);
			OUT_OFS, SET_OFS: nxt_rdata = hiPort ? 32'(prt_ff.outv[NPIN-1:P0W]) : prt_ff.outv[P0W-1:0];
			CLR_OFS, NOT_OFS: nxt_rdata = ZERO32;
			SEL_LO_OFS: nxt_rdata = hiPort ? 32'(cfg_ff.sel[NSEL*SELW-1:P0W]) : cfg_ff.sel[P0W-1:0];
			MODE_OFS: nxt_rdata = hiPort ? 32'(cfg_ff.rise) : 32'(cfg_ff.mode);
			FALL_OFS: nxt_rdata = hiPort ? 32'(req_ff) : 32'(cfg_ff.fall);
			PLVL_OFS: nxt_rdata = hiPort ? 32'(cfg_ff.pedg) : 32'(cfg_ff.plvl);
			PEN_OFS: nxt_rdata = hiPort ? 32'(hit_ff) : 32'(cfg_ff.pen);
			GRP_OFS: nxt_rdata = hiPort ? cfg_ff.gpol[P0W-1:0] : cfg_ff.grp[P0W-1:0];
			GCTL_OFS: nxt_rdata = hiPort ? 32'(cfg_ff.grp[NPIN-1:P0W]) : 32'({groupIrq, cfg_ff.gctl});
			default: nxt_rerr = 1'b1;
		endcase
	end

	// ----------------------------------------------------------------
	// Write decode and register next state
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (st[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction : merge

	always_comb
	begin
		logic [31:0] be;
		logic [NPIN-1:0] wv, bm;
		logic [AW-1:0] a;
		be = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
		a = {awAddr_ff[AW-1:3], 3'b000};
		wv = awAddr_ff[2] ? {wData_ff[P1W-1:0], {P0W{1'b0}}} : {{P1W{1'b0}}, wData_ff};
		bm = awAddr_ff[2] ? {be[P1W-1:0], {P0W{1'b0}}} : {{P1W{1'b0}}, be};
		nxt_prt = prt_ff;
		nxt_cfg = cfg_ff;
		wrHit = 1'b1;
		if (wrDo)
		begin
			unique case (a)
				DIR_OFS: nxt_prt.dir = (prt_ff.dir & ~bm) | (wv & bm);
				MASK_OFS: nxt_prt.mask = (prt_ff.mask & ~bm) | (wv & bm);
				OUT_OFS: nxt_prt.outv = (prt_ff.outv & ~bm) | (wv & bm);
				MPIN_OFS: nxt_prt.outv = (prt_ff.outv & ~(bm & ~prt_ff.mask)) | (wv & bm & ~prt_ff.mask);
				SET_OFS: nxt_prt.outv = prt_ff.outv | (wv & bm);
				CLR_OFS: nxt_prt.outv = prt_ff.outv & ~(wv & bm);
				NOT_OFS: nxt_prt.outv = prt_ff.outv ^ (wv & bm);
				PIN_OFS: wrHit = 1'b0;
				SEL_LO_OFS:
				begin
					if (awAddr_ff[2])
						nxt_cfg.sel[NSEL*SELW-1:P0W] = (NSEL*SELW-P0W)'(merge(32'(cfg_ff.sel[NSEL*SELW-1:P0W]),
							wData_ff, wStrb_ff));
					else
						nxt_cfg.sel[P0W-1:0] = merge(cfg_ff.sel[P0W-1:0], wData_ff, wStrb_ff);
				end
				MODE_OFS:
				begin
					if (awAddr_ff[2])
						nxt_cfg.rise = NSEL'(merge(32'(cfg_ff.rise), wData_ff, wStrb_ff));
					else
						nxt_cfg.mode = NSEL'(merge(32'(cfg_ff.mode), wData_ff, wStrb_ff));
				end
				FALL_OFS:
				begin
					if (!awAddr_ff[2])
						nxt_cfg.fall = NSEL'(merge(32'(cfg_ff.fall), wData_ff, wStrb_ff));
				end
				PLVL_OFS:
				begin
					if (awAddr_ff[2])
						nxt_cfg.pedg = NSEL'(merge(32'(cfg_ff.pedg), wData_ff, wStrb_ff));
					else
						nxt_cfg.plvl = NSEL'(merge(32'(cfg_ff.plvl), wData_ff, wStrb_ff));
				end
				PEN_OFS:
				begin
					if (!awAddr_ff[2])
						nxt_cfg.pen = NSEL'(merge(32'(cfg_ff.pen), wData_ff, wStrb_ff));
				end
				GRP_OFS:
				begin
					if (awAddr_ff[2])
						nxt_cfg.gpol[P0W-1:0] = merge(cfg_ff.gpol[P0W-1:0], wData_ff, wStrb_ff);
					else
						nxt_cfg.grp[P0W-1:0] = merge(cfg_ff.grp[P0W-1:0], wData_ff, wStrb_ff);
				end
				GCTL_OFS:
				begin
					if (awAddr_ff[2])
						nxt_cfg.grp[NPIN-1:P0W] = P1W'(merge(32'(cfg_ff.grp[NPIN-1:P0W]), wData_ff, wStrb_ff));
					else
						nxt_cfg.gctl = 2'(merge(32'(cfg_ff.gctl), wData_ff, wStrb_ff));
				end
				default: wrHit = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sticky edge requests and term hits, write one to clear
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [NSEL-1:0] clrReq, clrHit;
		clrReq = '0;
		clrHit = '0;
		if (wrDo && awAddr_ff[2] && wStrb_ff[0])
		begin
			if ({awAddr_ff[AW-1:3], 3'b000} == FALL_OFS)
				clrReq = wData_ff[NSEL-1:0];
			if ({awAddr_ff[AW-1:3], 3'b000} == PEN_OFS)
				clrHit = wData_ff[NSEL-1:0];
		end
		// Set beats clear in the same cycle
		nxt_req = (req_ff & ~clrReq) | (edgeReq & ~cfg_ff.mode);
		nxt_hit = (hit_ff & ~clrHit) | ({NSEL{anyMatch}} & cfg_ff.pen);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prt_ff <= '0;
			cfg_ff <= '0;
			req_ff <= '0;
			hit_ff <= '0;
			selPrev_ff <= '0;
			prevMatch_ff <= 1'b0;
			groupIrq <= 1'b0;
			corePulse <= 1'b0;
		end
		else
		begin
			prt_ff <= nxt_prt;
			cfg_ff <= nxt_cfg;
			req_ff <= nxt_req;
			hit_ff <= nxt_hit;
			selPrev_ff <= selLvl;
			prevMatch_ff <= anyMatch;
			groupIrq <= groupHit;
			corePulse <= cfg_ff.gctl[PEV_EN] & anyMatch & ~prevMatch_ff;
		end
	end
	assign corePulsePin = corePulse;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [NPIN-1:0] wv_chk;
	assign wv_chk = (awAddr_ff[2] ? {wData_ff[P1W-1:0], {P0W{1'b0}}} : {{P1W{1'b0}}, wData_ff})
		& (awAddr_ff[2] ? {{8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}, {P0W{1'b0}}}
		: {{P1W{1'b0}}, {8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}});
	core_pulse_one_a: assert property (@(posedge clk) disable iff (!rstn) corePulse |=> !corePulse)
		else $error("core pulse longer than one cycle");
	dir_reset_a: assert property (@(posedge clk) disable iff (!rstn) $rose(rstn) |-> pinOe == '0)
		else $error("direction not cleared after reset");
	sync_two_a: assert property (@(posedge clk) disable iff (!rstn)
		syncB_ff == $past(pinIn, 2) || $past(!rstn, 2))
		else $error("pin synchroniser depth wrong");
	write_resp_a: assert property (@(posedge clk) disable iff (!rstn) wrDo |=> bValid_ff)
		else $error("write answer late");
	read_resp_a: assert property (@(posedge clk) disable iff (!rstn) rdDo |=> rValid_ff)
		else $error("read answer late");
	set_bits_a: assert property (@(posedge clk) disable iff (!rstn)
		wrDo && {awAddr_ff[AW-1:3], 3'b000} == SET_OFS |=> (pinOut & $past(wv_chk)) == $past(wv_chk))
		else $error("set write failed");
	edge_req_a: assert property (@(posedge clk) disable iff (!rstn)
		(edgeReq & ~cfg_ff.mode) != '0 |=> ($past(edgeReq & ~cfg_ff.mode) & ~req_ff) == '0)
		else $error("edge request lost");
	term_irq_a: assert property (@(posedge clk) disable iff (!rstn)
		anyMatch |=> termIrq == (termIrq | $past(cfg_ff.pen)))
		else $error("term interrupt not raised");
endmodule : gpint_top
`default_nettype wire

// ===== test/gpint_pins.sv
// Board-level model of the circuits that drive the 48 pins
`timescale 1ns/10ps
`default_nettype none
module gpint_pins
	import gpint_pkg::*;
(
	// Clock
	input wire logic clk,
	// Block side
	input wire logic [NPIN-1:0] pinOut,
	input wire logic [NPIN-1:0] pinOe,
	output logic [NPIN-1:0] pinIn,
	// Board drive
	input wire logic [NPIN-1:0] extLevel,
	input wire logic [NPIN-1:0] extEn
);
	logic floatPat;
	initial floatPat = 1'b0;
	// Undriven pins wander, so a stale level never looks valid
	always @(posedge clk)
		floatPat <= ~floatPat;
	always_comb
		for (int i = 0; i < NPIN; i++)
			pinIn[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extLevel[i] : floatPat);
endmodule : gpint_pins
`default_nettype wire

// ===== test/gpio_pin_interrupt_pattern_match_test.sv
// Self-checking testbench for the GPIO and pin interrupt block
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_interrupt_pattern_match_test
	import gpint_pkg::*;
;
	logic clk, rstn;
	logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [NPIN-1:0] pinIn, pinOut, pinOe, extLevel, extEn;
	logic [NSEL-1:0] pinIrq, termIrq;
	logic groupIrq, corePulse, corePulsePin, patWakeDeepOk;
	int mismatches = 0;
	int nChecks = 0;
	int cycles = 0;
	gpint_top dut_u (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinIn, .pinOut, .pinOe,
		.pinIrq, .termIrq, .groupIrq, .corePulse, .corePulsePin, .patWakeDeepOk);
	gpint_pins pins_u (.clk, .pinOut, .pinOe, .pinIn, .extLevel, .extEn);
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t timeout", $time);
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		nChecks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// ----------------------------------------
	// Bus master
	// ----------------------------------------
	// Trailing edge keeps bready from being assigned twice in one step
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w || s_axi_bvalid !== 1'b1)
		begin
			@(posedge clk);
			if (aw && s_axi_awready)
			begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready)
			begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
		@(posedge clk);
	endtask : axiWr
	task automatic axiRd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
		logic ar;
		ar = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (ar || s_axi_rvalid !== 1'b1)
		begin
			@(posedge clk);
			if (ar && s_axi_arready)
			begin
				ar = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, exp, what);
		chk({30'h0, s_axi_rresp}, {30'h0, er}, what);
		@(posedge clk);
	endtask : axiRd
	function automatic logic sig(input int k);
		case (k)
			0: sig = pinIrq[0];
			1: sig = termIrq[0];
			default: sig = groupIrq;
		endcase
	endfunction : sig
	task automatic waitSig(input int k, input logic v, input string what);
		int t;
		t = 0;
		while (sig(k) !== v && t < 8)
		begin
			@(posedge clk);
			t++;
		end
		chk({31'h0, sig(k)}, {31'h0, v}, what);
	endtask : waitSig
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic tPort();
		chk(pinOe[31:0] | {16'h0, pinOe[47:32]}, ZERO32, "oe reset");
		axiRd(DIR_OFS + 8'h04, ZERO32, RESP_OK, "dir1");
		chk({31'h0, patWakeDeepOk}, ZERO32, "deep");
		axiWr(DIR_OFS, 32'hffffffff, 4'hf, RESP_OK);
		axiWr(OUT_OFS, 32'h12345678, 4'hf, RESP_OK);
		axiWr(OUT_OFS, 32'haaaaaaaa, 4'h2, RESP_OK);
		axiWr(OUT_OFS, 32'hbeef0000, 4'hc, RESP_OK);
		axiRd(OUT_OFS, 32'hbeefaa78, RESP_OK, "out");
		chk(pinOe[31:0], 32'hffffffff, "oe");
		axiWr(SET_OFS, 32'h0000000f, 4'hf, RESP_OK);
		axiWr(CLR_OFS, 32'h00000003, 4'hf, RESP_OK);
		axiWr(NOT_OFS, 32'h000000f0, 4'hf, RESP_OK);
		chk(pinOut[31:0], 32'hbeefaa8c, "setclr");
		chk({16'h0, pinOut[47:32]}, ZERO32, "port1 kept");
		extLevel[47:32] <= 16'h5a5a;
		repeat (4) @(posedge clk);
		axiRd(PIN_OFS + 8'h04, 32'h00005a5a, RESP_OK, "pin1");
		axiRd(PIN_OFS, 32'hbeefaa8c, RESP_OK, "pin0");
		axiWr(MASK_OFS, 32'hffff0000, 4'hf, RESP_OK);
		axiRd(MPIN_OFS, 32'h0000aa8c, RESP_OK, "mpin");
		axiWr(MPIN_OFS, 32'h00001111, 4'hf, RESP_OK);
		axiRd(OUT_OFS, 32'hbeef1111, RESP_OK, "mout");
		axiWr(MASK_OFS, ZERO32, 4'hf, RESP_OK);
		axiRd(8'hfc, ZERO32, RESP_ERR, "unmapped");
		axiWr(PIN_OFS, ZERO32, 4'hf, RESP_ERR);
		axiRd(OUT_OFS, 32'hbeef1111, RESP_OK, "no effect");
		$display("test port done");
	endtask : tPort
	task automatic tPinIrq();
		extLevel[40] <= 1'b0;
		axiWr(SEL_LO_OFS, 32'h00000028, 4'hf, RESP_OK);
		axiWr(RISE_OFS, 32'h00000001, 4'hf, RESP_OK);
		extLevel[40] <= 1'b1;
		waitSig(0, 1'b1, "rise");
		chk({24'h0, pinIrq[7:1], 1'b0}, ZERO32, "others");
		axiRd(REQ_OFS, 32'h00000001, RESP_OK, "req");
		axiWr(REQ_OFS, 32'h00000001, 4'hf, RESP_OK);
		waitSig(0, 1'b0, "clear");
		axiWr(FALL_OFS, 32'h00000001, 4'hf, RESP_OK);
		extLevel[40] <= 1'b0;
		waitSig(0, 1'b1, "fall");
		axiWr(REQ_OFS, 32'h00000001, 4'hf, RESP_OK);
		waitSig(0, 1'b0, "clear2");
		axiWr(MODE_OFS, 32'h00000001, 4'hf, RESP_OK);
		waitSig(0, 1'b1, "low level");
		extLevel[40] <= 1'b1;
		waitSig(0, 1'b0, "level gone");
		axiWr(FALL_OFS, ZERO32, 4'hf, RESP_OK);
		waitSig(0, 1'b1, "high level");
		axiWr(MODE_OFS, ZERO32, 4'hf, RESP_OK);
		axiWr(RISE_OFS, ZERO32, 4'hf, RESP_OK);
		axiWr(REQ_OFS, 32'h000000ff, 4'hf, RESP_OK);
		$display("test pin interrupt done");
	endtask : tPinIrq
	task automatic tPattern();
		int n;
		n = 0;
		extLevel[40] <= 1'b0;
		axiWr(PLVL_OFS, 32'h00000001, 4'hf, RESP_OK);
		axiWr(PEN_OFS, 32'h00000001, 4'hf, RESP_OK);
		axiWr(GCTL_OFS, 32'h00000002, 4'hf, RESP_OK);
		extLevel[40] <= 1'b1;
		repeat (20)
		begin
			@(posedge clk);
			n += corePulse;
			chk({31'h0, corePulsePin}, {31'h0, corePulse}, "event pin");
		end
		chk(n, 32'h00000001, "pulses");
		chk({31'h0, termIrq[0]}, 32'h00000001, "term");
		extLevel[40] <= 1'b0;
		repeat (4) @(posedge clk);
		axiWr(PHIT_OFS, 32'h00000001, 4'hf, RESP_OK);
		waitSig(1, 1'b0, "term clear");
		axiWr(PEDG_OFS, 32'h00000001, 4'hf, RESP_OK);
		extLevel[40] <= 1'b1;
		waitSig(1, 1'b1, "edge term");
		$display("test pattern done");
	endtask : tPattern
	task automatic tGroup();
		axiWr(GRP_OFS, 32'h00000003, 4'hf, RESP_OK);
		axiWr(GPOL_OFS, 32'h00000003, 4'hf, RESP_OK);
		axiWr(GCTL_OFS, 32'h00000001, 4'hf, RESP_OK);
		axiWr(CLR_OFS, 32'h00000003, 4'hf, RESP_OK);
		axiWr(SET_OFS, 32'h00000001, 4'hf, RESP_OK);
		repeat (6) @(posedge clk);
		chk({31'h0, groupIrq}, ZERO32, "and partial");
		axiWr(SET_OFS, 32'h00000002, 4'hf, RESP_OK);
		waitSig(2, 1'b1, "and full");
		axiWr(GCTL_OFS, ZERO32, 4'hf, RESP_OK);
		axiWr(CLR_OFS, 32'h00000001, 4'hf, RESP_OK);
		repeat (6) @(posedge clk);
		chk({31'h0, groupIrq}, 32'h00000001, "or one");
		axiWr(CLR_OFS, 32'h00000002, 4'hf, RESP_OK);
		waitSig(2, 1'b0, "or none");
		$display("test group done");
	endtask : tGroup
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		extLevel = '0;
		extEn = '1;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		tPort();
		tPinIrq();
		tPattern();
		tGroup();
		results();
	end
endmodule : gpio_pin_interrupt_pattern_match_test
`default_nettype wire
